// [cdp_pkg.sv]
// Package for the codec digital path control block: register map, fields, constants.
// Assumes a 32-bit Avalon-MM slave with word addresses equal to four times the register index.
// How it works
// - Playback gain code, 0.5dB steps, 0xC8 unity
// - Playback commit bit applies both pending gains
// - Playback zero cross defers gain change
// - Soft mute decays toward midpoint, 64 samples
// - Mute release resumes from current sample
// - Mono mix selects stereo, copy or average
// - Control bit 6 inserts de-emphasis filter
// - No de-emphasis at 192fs ratio
// - Mirror bit copies writes to second converter
// - Record gain code, mute, 0xC3 unity
// - Record commit bit applies both pending gains
// - Record zero cross defers gain change
// - Record swap exchanges left and right
// - Bits 8 and 9 invert right, left
// - Output select picks slot data
// - High-pass active unless bit 12 set
// - Playback converter runs only when enabled
package cdp_pkg;
  localparam int unsigned DATA_W = 24;
  localparam logic [4:0] IDX_PLAY1_CTRL = 5'h02;
  localparam logic [4:0] IDX_PLAY1_LGAIN = 5'h05;
  localparam logic [4:0] IDX_PLAY1_RGAIN = 5'h06;
  localparam logic [4:0] IDX_PLAY2_CTRL = 5'h07;
  localparam logic [4:0] IDX_PLAY2_LGAIN = 5'h0A;
  localparam logic [4:0] IDX_PLAY2_RGAIN = 5'h0B;
  localparam logic [4:0] IDX_MIRROR = 5'h0C;
  localparam logic [4:0] IDX_REC_CTRL = 5'h0D;
  localparam logic [4:0] IDX_REC_LGAIN = 5'h10;
  localparam logic [4:0] IDX_REC_RGAIN = 5'h11;
  localparam logic [4:0] IDX_STATUS = 5'h12;
  localparam logic [4:0] MIRROR_SPAN = 5'h05;
  localparam int unsigned BIT_COMMIT = 8;
  localparam int unsigned BIT_PZC = 7;
  localparam int unsigned BIT_DEEMPH = 6;
  localparam int unsigned BIT_PEN = 8;
  localparam int unsigned BIT_MUTE = 9;
  localparam int unsigned BIT_MIX = 10;
  localparam int unsigned BIT_MIRROR = 1;
  localparam int unsigned BIT_SWAP = 7;
  localparam int unsigned BIT_RINV = 8;
  localparam int unsigned BIT_LINV = 9;
  localparam int unsigned BIT_OSEL = 10;
  localparam int unsigned BIT_HPD = 12;
  localparam int unsigned BIT_RZC = 13;
  localparam logic [15:0] RST_PLAY_CTRL = 16'h0080;
  localparam logic [15:0] RST_PLAY_GAIN = 16'h00C8;
  localparam logic [15:0] RST_REC_CTRL = 16'h2000;
  localparam logic [15:0] RST_REC_GAIN = 16'h00C3;
  localparam logic [7:0] PLAY_UNITY = 8'hC8;
  localparam logic [7:0] PLAY_MAX = 8'hE0;
  localparam logic [7:0] REC_UNITY = 8'hC3;
  localparam int unsigned MUTE_SHIFT = 6;
  localparam int unsigned HPF_SHIFT = 10;
  localparam int unsigned DEEMPH_SHIFT = 2;
  localparam logic [2:0] RATIO_192FS = 3'h2;
  typedef enum logic [1:0] {
    CDP_MIX_STEREO = 2'b00,
    CDP_MIX_LEFT = 2'b01,
    CDP_MIX_RIGHT = 2'b10,
    CDP_MIX_AVG = 2'b11
  } cdp_mix_t;
  typedef struct packed {
    logic signed [DATA_W-1:0] left;
    logic signed [DATA_W-1:0] right;
  } cdp_pair_t;
endpackage

// [cdp_top.sv]
// Codec digital path control: register file, two playback paths and the record path.
// Assumes one 50 MHz clock; per-path sample strobes are single-cycle pulses on that clock.
//
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module cdp_top (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic [6:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  output logic [1:0] avs_response_o,
  input wire logic [2:0] play1_ratio_i,
  input wire logic [2:0] play2_ratio_i,
  input wire logic play1_strobe_i,
  input wire logic play2_strobe_i,
  input wire logic rec_strobe_i,
  input wire cdp_pkg::cdp_pair_t play1_data_i,
  input wire cdp_pkg::cdp_pair_t play2_data_i,
  input wire cdp_pkg::cdp_pair_t rec_data_i,
  output cdp_pkg::cdp_pair_t play1_data_o,
  output cdp_pkg::cdp_pair_t play2_data_o,
  output cdp_pkg::cdp_pair_t rec_data_o,
  output logic play1_valid_o,
  output logic play2_valid_o,
  output logic rec_valid_o
);
  import cdp_pkg::*;

  logic rst_meta, rst_n;
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // Register bank: [0..2]=play1 ctrl,L,R; [3..5]=play2; [6]=mirror; [7..9]=record
  logic [15:0] regs [10];
  logic [15:0] next_regs [10];
  logic [31:0] rdata, next_rdata;
  logic ack, next_ack;
  logic [1:0] resp, next_resp;
  logic [4:0] idx;
  logic [15:0] wval;
  logic hit;
  int slot;
  logic [2:0] p_commit, next_p_commit; // bit0 play1, bit1 play2, bit2 record
  logic [2:0] p_commit_q;
  logic [1:0] p_str;
  logic [2:0] p_ratio [2];
  cdp_pair_t p_in [2];
  cdp_pair_t q_out [2];
  logic [1:0] q_valid;

  assign idx = avs_address_i[6:2];

  always_comb begin
    wval = avs_writedata_i[15:0];
    slot = -1;
    unique case (idx)
      IDX_PLAY1_CTRL: slot = 0;
      IDX_PLAY1_LGAIN: slot = 1;
      IDX_PLAY1_RGAIN: slot = 2;
      IDX_PLAY2_CTRL: slot = 3;
      IDX_PLAY2_LGAIN: slot = 4;
      IDX_PLAY2_RGAIN: slot = 5;
      IDX_MIRROR: slot = 6;
      IDX_REC_CTRL: slot = 7;
      IDX_REC_LGAIN: slot = 8;
      IDX_REC_RGAIN: slot = 9;
      default: slot = -1;
    endcase
    hit = (slot >= 0) || (idx == IDX_STATUS);
    if (avs_byteenable_i[0] == 1'b0 && slot >= 0) wval[7:0] = regs[slot][7:0];
    if (avs_byteenable_i[1] == 1'b0 && slot >= 0) wval[15:8] = regs[slot][15:8];
  end

  // One-wait-state answer: one cycle of waitrequest, then acknowledge
  always_comb begin
    for (int i = 0; i < 10; i++) next_regs[i] = regs[i];
    next_ack = 1'b0;
    next_rdata = rdata;
    next_resp = resp;
    next_p_commit = 3'b000;
    if ((avs_read_i || avs_write_i) && !ack) begin
      next_ack = 1'b1;
      next_resp = hit ? 2'b00 : 2'b10;
      next_rdata = 32'h0000_0000;
      if (avs_read_i && slot >= 0) next_rdata = {16'h0000, regs[slot]};
      if (avs_read_i && idx == IDX_STATUS) next_rdata = {29'h0, p_commit_q};
      if (avs_write_i && slot >= 0) begin
        next_regs[slot] = wval;
        if (slot == 1 || slot == 2) next_p_commit[0] = wval[BIT_COMMIT];
        if (slot == 4 || slot == 5) next_p_commit[1] = wval[BIT_COMMIT];
        if (slot == 8 || slot == 9) next_p_commit[2] = wval[BIT_COMMIT];
        if (slot <= 2 && regs[6][BIT_MIRROR]) begin
          next_regs[slot + 3] = wval;
          if (slot != 0) next_p_commit[1] = wval[BIT_COMMIT];
        end
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      regs[0] <= RST_PLAY_CTRL;
      regs[1] <= RST_PLAY_GAIN;
      regs[2] <= RST_PLAY_GAIN;
      regs[3] <= RST_PLAY_CTRL;
      regs[4] <= RST_PLAY_GAIN;
      regs[5] <= RST_PLAY_GAIN;
      regs[6] <= 16'h0000;
      regs[7] <= RST_REC_CTRL;
      regs[8] <= RST_REC_GAIN;
      regs[9] <= RST_REC_GAIN;
      rdata <= 32'h0000_0000;
      ack <= 1'b0;
      resp <= 2'b00;
      p_commit_q <= 3'b000;
    end else if (clk_en_i) begin
      for (int i = 0; i < 10; i++) regs[i] <= next_regs[i];
      rdata <= next_rdata;
      ack <= next_ack;
      resp <= next_resp;
      p_commit_q <= next_p_commit;
    end
  end

  assign avs_readdata_o = rdata;
  assign avs_waitrequest_o = ~ack;
  assign avs_response_o = resp;

  assign p_str = {play2_strobe_i, play1_strobe_i};
  assign p_ratio[0] = play1_ratio_i;
  assign p_ratio[1] = play2_ratio_i;
  assign p_in[0] = play1_data_i;
  assign p_in[1] = play2_data_i;

  // Playback converter per instance
  for (genvar c = 0; c < 2; c++) begin : g_play
    logic [15:0] ctl_act, next_ctl_act;
    logic [7:0] gl_act, gr_act, next_gl_act, next_gr_act;
    logic [7:0] gl_pend, gr_pend, next_gl_pend, next_gr_pend;
    logic pend, next_pend;
    logic signed [DATA_W-1:0] mute_l, mute_r, next_mute_l, next_mute_r;
    logic signed [DATA_W-1:0] de_l, de_r, next_de_l, next_de_r;
    logic signed [DATA_W-1:0] prev_l, prev_r, next_prev_l, next_prev_r;
    cdp_pair_t out, next_out;
    logic vld, next_vld;
    logic signed [DATA_W:0] sum;
    logic signed [DATA_W-1:0] mx_l, mx_r, f_l, f_r;
    logic zc_l, zc_r;
    logic [7:0] cl, cr;

    // Linear approximation: unity at 0xC8, code 0 silenced
    function automatic logic signed [DATA_W-1:0] apply_play(
        input logic signed [DATA_W-1:0] x, input logic [7:0] code);
      logic signed [DATA_W+8:0] p;
      logic [8:0] k;
      k = (code >= PLAY_MAX) ? {1'b0, PLAY_MAX} : {1'b0, code};
      p = x * $signed({1'b0, k});
      apply_play = (code == 8'h00) ? '0 : DATA_W'(p / $signed({1'b0, 9'(PLAY_UNITY)}));
    endfunction

    always_comb begin
      next_ctl_act = ctl_act;
      next_gl_pend = gl_pend;
      next_gr_pend = gr_pend;
      next_pend = pend;
      next_gl_act = gl_act;
      next_gr_act = gr_act;
      next_mute_l = mute_l;
      next_mute_r = mute_r;
      next_de_l = de_l;
      next_de_r = de_r;
      next_prev_l = prev_l;
      next_prev_r = prev_r;
      next_out = out;
      next_vld = 1'b0;
      sum = '0;
      mx_l = '0;
      mx_r = '0;
      f_l = '0;
      f_r = '0;
      zc_l = 1'b0;
      zc_r = 1'b0;
      cl = regs[3*c+1][7:0];
      cr = regs[3*c+2][7:0];
      if (p_commit_q[c]) begin
        next_gl_pend = cl;
        next_gr_pend = cr;
        next_pend = 1'b1;
      end
      if (p_str[c]) begin
        next_ctl_act = regs[3*c];
        if (ctl_act[BIT_PEN]) begin
          sum = $signed({p_in[c].left[DATA_W-1], p_in[c].left})
              + $signed({p_in[c].right[DATA_W-1], p_in[c].right});
          unique case (cdp_mix_t'(ctl_act[BIT_MIX +: 2]))
            CDP_MIX_STEREO: {mx_l, mx_r} = {p_in[c].left, p_in[c].right};
            CDP_MIX_LEFT: {mx_l, mx_r} = {p_in[c].left, p_in[c].left};
            CDP_MIX_RIGHT: {mx_l, mx_r} = {p_in[c].right, p_in[c].right};
            CDP_MIX_AVG: {mx_l, mx_r} = {sum[DATA_W:1], sum[DATA_W:1]};
          endcase
          // De-emphasis as a one-pole shelf; withheld at 192fs
          if (ctl_act[BIT_DEEMPH] && p_ratio[c] != RATIO_192FS) begin
            next_de_l = de_l + ((mx_l - de_l) >>> DEEMPH_SHIFT);
            next_de_r = de_r + ((mx_r - de_r) >>> DEEMPH_SHIFT);
            f_l = next_de_l;
            f_r = next_de_r;
          end else begin
            next_de_l = mx_l;
            next_de_r = mx_r;
            f_l = mx_l;
            f_r = mx_r;
          end
          zc_l = (f_l[DATA_W-1] != prev_l[DATA_W-1]) || (f_l == '0);
          zc_r = (f_r[DATA_W-1] != prev_r[DATA_W-1]) || (f_r == '0);
          next_prev_l = f_l;
          next_prev_r = f_r;
          if (pend && (!ctl_act[BIT_PZC] || (zc_l && zc_r))) begin
            next_gl_act = gl_pend;
            next_gr_act = gr_pend;
            next_pend = p_commit_q[c];
          end
          f_l = apply_play(f_l, gl_act);
          f_r = apply_play(f_r, gr_act);
          if (ctl_act[BIT_MUTE]) begin
            next_mute_l = mute_l - (mute_l >>> MUTE_SHIFT);
            next_mute_r = mute_r - (mute_r >>> MUTE_SHIFT);
          end else begin
            next_mute_l = f_l;
            next_mute_r = f_r;
          end
          next_out.left = next_mute_l;
          next_out.right = next_mute_r;
          next_vld = 1'b1;
        end
      end
    end

    always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
        ctl_act <= RST_PLAY_CTRL;
        gl_act <= PLAY_UNITY;
        gr_act <= PLAY_UNITY;
        gl_pend <= PLAY_UNITY;
        gr_pend <= PLAY_UNITY;
        pend <= 1'b0;
        mute_l <= '0;
        mute_r <= '0;
        de_l <= '0;
        de_r <= '0;
        prev_l <= '0;
        prev_r <= '0;
        out <= '0;
        vld <= 1'b0;
      end else if (clk_en_i) begin
        ctl_act <= next_ctl_act;
        gl_act <= next_gl_act;
        gr_act <= next_gr_act;
        gl_pend <= next_gl_pend;
        gr_pend <= next_gr_pend;
        pend <= next_pend;
        mute_l <= next_mute_l;
        mute_r <= next_mute_r;
        de_l <= next_de_l;
        de_r <= next_de_r;
        prev_l <= next_prev_l;
        prev_r <= next_prev_r;
        out <= next_out;
        vld <= next_vld;
      end
    end
    assign q_out[c] = out;
    assign q_valid[c] = vld;
  end

  assign play1_data_o = q_out[0];
  assign play2_data_o = q_out[1];
  assign play1_valid_o = q_valid[0];
  assign play2_valid_o = q_valid[1];

  // Record path
  logic [15:0] rc_act, next_rc_act;
  logic [7:0] rl_act, rr_act, next_rl_act, next_rr_act;
  logic [7:0] rl_pend, rr_pend, next_rl_pend, next_rr_pend;
  logic r_pend, next_r_pend;
  logic signed [DATA_W-1:0] hp_l, hp_r, next_hp_l, next_hp_r;
  logic signed [DATA_W-1:0] rprev_l, rprev_r, next_rprev_l, next_rprev_r;
  cdp_pair_t rout, next_rout;
  logic rvld, next_rvld;
  logic signed [DATA_W-1:0] a_l, a_r, s_l, s_r, h_l, h_r;

  // Linear approximation: unity at 0xC3, code 0 is digital mute
  function automatic logic signed [DATA_W-1:0] apply_rec(
      input logic signed [DATA_W-1:0] x, input logic [7:0] code);
    logic signed [DATA_W+8:0] p;
    p = x * $signed({1'b0, code});
    apply_rec = (code == 8'h00) ? '0 : DATA_W'(p / $signed({1'b0, REC_UNITY}));
  endfunction

  always_comb begin
    next_rc_act = rc_act;
    next_rl_act = rl_act;
    next_rr_act = rr_act;
    next_rl_pend = rl_pend;
    next_rr_pend = rr_pend;
    next_r_pend = r_pend;
    next_hp_l = hp_l;
    next_hp_r = hp_r;
    next_rprev_l = rprev_l;
    next_rprev_r = rprev_r;
    next_rout = rout;
    next_rvld = 1'b0;
    if (p_commit_q[2]) begin
      next_rl_pend = regs[8][7:0];
      next_rr_pend = regs[9][7:0];
      next_r_pend = 1'b1;
    end
    a_l = rc_act[BIT_SWAP] ? rec_data_i.right : rec_data_i.left;
    a_r = rc_act[BIT_SWAP] ? rec_data_i.left : rec_data_i.right;
    unique case (rc_act[BIT_OSEL +: 2])
      2'b00: {s_l, s_r} = {a_l, a_r};
      2'b01: {s_l, s_r} = {a_l, a_l};
      2'b10: {s_l, s_r} = {a_r, a_r};
      2'b11: {s_l, s_r} = {a_r, a_l};
    endcase
    // High-pass as input minus tracked DC estimate
    h_l = s_l;
    h_r = s_r;
    if (!rc_act[BIT_HPD]) begin
      next_hp_l = rec_strobe_i ? hp_l + ((s_l - hp_l) >>> HPF_SHIFT) : hp_l;
      next_hp_r = rec_strobe_i ? hp_r + ((s_r - hp_r) >>> HPF_SHIFT) : hp_r;
      h_l = s_l - hp_l;
      h_r = s_r - hp_r;
    end
    if (rc_act[BIT_LINV]) h_l = -h_l;
    if (rc_act[BIT_RINV]) h_r = -h_r;
    if (rec_strobe_i) begin
      next_rc_act = regs[7];
      next_rprev_l = h_l;
      next_rprev_r = h_r;
      if (r_pend && (!rc_act[BIT_RZC] ||
          ((h_l[DATA_W-1] != rprev_l[DATA_W-1] || h_l == '0) &&
           (h_r[DATA_W-1] != rprev_r[DATA_W-1] || h_r == '0)))) begin
        next_rl_act = rl_pend;
        next_rr_act = rr_pend;
        next_r_pend = p_commit_q[2];
      end
      next_rout.left = apply_rec(h_l, rl_act);
      next_rout.right = apply_rec(h_r, rr_act);
      next_rvld = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      rc_act <= RST_REC_CTRL;
      rl_act <= REC_UNITY;
      rr_act <= REC_UNITY;
      rl_pend <= REC_UNITY;
      rr_pend <= REC_UNITY;
      r_pend <= 1'b0;
      hp_l <= '0;
      hp_r <= '0;
      rprev_l <= '0;
      rprev_r <= '0;
      rout <= '0;
      rvld <= 1'b0;
    end else if (clk_en_i) begin
      rc_act <= next_rc_act;
      rl_act <= next_rl_act;
      rr_act <= next_rr_act;
      rl_pend <= next_rl_pend;
      rr_pend <= next_rr_pend;
      r_pend <= next_r_pend;
      hp_l <= next_hp_l;
      hp_r <= next_hp_r;
      rprev_l <= next_rprev_l;
      rprev_r <= next_rprev_r;
      rout <= next_rout;
      rvld <= next_rvld;
    end
  end

  assign rec_data_o = rout;
  assign rec_valid_o = rvld;
endmodule

// [cdp_checker.sv]
// Checker for cdp_top: bus handshake timing and sample output pacing.
// Assumes it is bound to cdp_top and sees only that module's ports.
`timescale 1ns/1ps
module cdp_checker (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic avs_waitrequest_o,
  input wire logic [1:0] avs_response_o,
  input wire logic play1_strobe_i,
  input wire logic play2_strobe_i,
  input wire logic rec_strobe_i,
  input wire cdp_pkg::cdp_pair_t play1_data_o,
  input wire cdp_pkg::cdp_pair_t rec_data_o,
  input wire logic play1_valid_o,
  input wire logic play2_valid_o,
  input wire logic rec_valid_o
);
  import cdp_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  a_bus_answer_next: assert property ($rose(avs_read_i || avs_write_i) && clk_en_i
    |=> !avs_waitrequest_o) else $error("bus answer not one cycle after request");
  a_wait_one_cycle: assert property (!avs_waitrequest_o |=> avs_waitrequest_o)
    else $error("waitrequest low for more than one cycle");
  a_no_request_idle: assert property (!(avs_read_i || avs_write_i) |=> avs_waitrequest_o)
    else $error("answer without request");
  a_upper_half_zero: assert property (!avs_waitrequest_o |-> avs_readdata_o[31:16] == 16'h0000)
    else $error("upper read data not zero");
  a_error_data_zero: assert property (!avs_waitrequest_o && avs_response_o == 2'b10
    |-> avs_readdata_o == 32'h0000_0000) else $error("error answer carries data");
  a_play1_valid_cause: assert property (play1_valid_o |-> $past(play1_strobe_i))
    else $error("play1 output without sample strobe");
  a_play2_valid_cause: assert property (play2_valid_o |-> $past(play2_strobe_i))
    else $error("play2 output without sample strobe");
  a_rec_sample_pulse: assert property (rec_strobe_i |=> rec_valid_o ##1 !rec_valid_o)
    else $error("record output pulse missing");
  a_rec_data_hold: assert property (!rec_valid_o |-> $stable(rec_data_o))
    else $error("record output changed off sample boundary");
  a_play1_data_hold: assert property (!play1_valid_o |-> $stable(play1_data_o))
    else $error("play1 output changed off sample boundary");
endmodule

bind cdp_top cdp_checker cdp_checker_inst (.clk_i(clk_i), .reset_n_i(reset_n_i),
  .clk_en_i(clk_en_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .avs_response_o(avs_response_o), .play1_strobe_i(play1_strobe_i),
  .play2_strobe_i(play2_strobe_i), .rec_strobe_i(rec_strobe_i),
  .play1_data_o(play1_data_o), .rec_data_o(rec_data_o), .play1_valid_o(play1_valid_o),
  .play2_valid_o(play2_valid_o), .rec_valid_o(rec_valid_o));

// [cdp_source.sv]
// Sample source model: one strobe pulse per request, data valid only with it.
// Assumes requests are spaced at least three cycles apart.
`timescale 1ns/1ps
module cdp_source (
  input wire logic clk_i,
  input wire logic go_i,
  input wire cdp_pkg::cdp_pair_t sample_i,
  output logic strobe_o,
  output cdp_pkg::cdp_pair_t data_o
);
  import cdp_pkg::*;
  initial begin
    strobe_o = 1'b0;
    data_o = '0;
  end
  // Outside the strobe the lines toggle so stale data cannot pass
  always @(posedge clk_i) begin
    strobe_o <= go_i;
    data_o <= go_i ? sample_i : ~data_o;
  end
endmodule

// [cdp_top_tb.sv]
// Self-checking bench for cdp_top: registers over Avalon-MM and the three sample paths.
// Assumes cdp_pkg, cdp_source and the bound checker are compiled first.
`timescale 1ns/1ps
module cdp_top_tb;
  import cdp_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [6:0] avs_address_i = '0;
  logic avs_read_i = 1'b0;
  logic avs_write_i = 1'b0;
  logic [31:0] avs_writedata_i = '0;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  logic [1:0] avs_response_o;
  logic [2:0] play1_ratio_i = 3'h0;
  logic [2:0] go = '0;
  logic [2:0] stb;
  logic [2:0] vld;
  cdp_pair_t [2:0] smp = '0;
  cdp_pair_t [2:0] din;
  cdp_pair_t [2:0] dout;
  int fail_count = 0;
  int n_tests = 0;
  int cycles = 0;
  logic [31:0] rng = 32'hE58B;
  logic [15:0] rd;
  logic [1:0] rsp;
  cdp_pair_t s, r;
  logic [4:0] tidx [10] = '{IDX_PLAY1_CTRL, IDX_PLAY1_LGAIN, IDX_PLAY1_RGAIN, IDX_PLAY2_CTRL,
    IDX_PLAY2_LGAIN, IDX_PLAY2_RGAIN, IDX_MIRROR, IDX_REC_CTRL, IDX_REC_LGAIN, IDX_REC_RGAIN};
  logic [15:0] tval [10] = '{16'h0080, 16'h00C8, 16'h00C8, 16'h0080, 16'h00C8, 16'h00C8,
    16'h0000, 16'h2000, 16'h00C3, 16'h00C3};

  always #10 clk_i = ~clk_i;

  cdp_source cdp_source_inst [2:0] (.clk_i(clk_i), .go_i(go), .sample_i(smp),
    .strobe_o(stb), .data_o(din));

  cdp_top cdp_top_inst (.clk_i(clk_i), .reset_n_i(reset_n_i), .clk_en_i(1'b1),
    .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(4'h3),
    .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
    .avs_response_o(avs_response_o), .play1_ratio_i(play1_ratio_i), .play2_ratio_i(3'h0),
    .play1_strobe_i(stb[0]), .play2_strobe_i(stb[1]), .rec_strobe_i(stb[2]),
    .play1_data_i(din[0]), .play2_data_i(din[1]), .rec_data_i(din[2]),
    .play1_data_o(dout[0]), .play2_data_o(dout[1]), .rec_data_o(dout[2]),
    .play1_valid_o(vld[0]), .play2_valid_o(vld[1]), .rec_valid_o(vld[2]));

  task automatic final_report();
    if (fail_count == 0 && n_tests > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      fail_count++;
      final_report();
    end
  end

  task automatic check(input logic [47:0] seen, input logic [47:0] exp);
    n_tests++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t saw %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic bus(input logic wr, input logic [4:0] idx, input logic [15:0] wd);
    int n;
    avs_address_i <= {idx, 2'b00};
    avs_writedata_i <= {16'h0000, wd};
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    rd = avs_readdata_o[15:0];
    rsp = avs_response_o;
    check(48'(n < 50), 48'h1);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    @(posedge clk_i);
  endtask

  function automatic cdp_pair_t rnd();
    cdp_pair_t o;
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    o.left = {{3{rng[20]}}, rng[20:1], 1'b0};
    o.right = {{3{rng[31]}}, rng[31:12], 1'b0};
    return o;
  endfunction

  task automatic send(input int p, input cdp_pair_t v, output cdp_pair_t o);
    int n;
    smp[p] <= v;
    go[p] <= 1'b1;
    @(posedge clk_i);
    go[p] <= 1'b0;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (vld[p] !== 1'b1 && n < 8);
    o = dout[p];
  endtask

  // Write a setting, let one sample boundary take it, then send v
  task automatic setsend(input int p, input logic [4:0] idx, input logic [15:0] wd,
                         input cdp_pair_t v, output cdp_pair_t o);
    bus(1'b1, idx, wd);
    send(p, v, o);
    send(p, v, o);
  endtask

  function automatic cdp_pair_t mixf(cdp_pair_t v, logic [1:0] m);
    cdp_pair_t o;
    o = v;
    if (m == 2'b01) o.right = v.left;
    if (m == 2'b10) o.left = v.right;
    if (m == 2'b11) begin
      o.left = (v.left + v.right) >>> 1;
      o.right = o.left;
    end
    return o;
  endfunction

  // Swap, then slot select, then inversion
  function automatic cdp_pair_t recf(cdp_pair_t v, logic [4:0] k);
    cdp_pair_t a, o;
    a.left = k[0] ? v.right : v.left;
    a.right = k[0] ? v.left : v.right;
    o.left = k[4] ? a.right : a.left;
    o.right = k[3] ? a.left : a.right;
    if (k[2]) o.left = -o.left;
    if (k[1]) o.right = -o.right;
    return o;
  endfunction

  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    for (int i = 0; i < 10; i++) begin
      bus(1'b0, tidx[i], 16'h0000);
      check(48'(rd), 48'(tval[i]));
    end
    bus(1'b1, 5'h1F, 16'hFFFF);
    bus(1'b0, 5'h1F, 16'h0000);
    check(48'({rsp, rd}), 48'h20000);
    s = rnd();
    send(0, s, r);
    check(r, 48'h0);
    bus(1'b1, IDX_MIRROR, 16'h0002);
    bus(1'b1, IDX_PLAY1_CTRL, 16'h0100);
    bus(1'b1, IDX_PLAY1_LGAIN, 16'h00C8);
    bus(1'b1, IDX_PLAY1_RGAIN, 16'h00C8);
    for (int i = 3; i < 6; i++) begin
      bus(1'b0, tidx[i], 16'h0000);
      check(48'(rd), 48'(i == 3 ? 16'h0100 : 16'h00C8));
    end
    s = rnd();
    // First strobe only loads the mirrored control
    send(1, s, r);
    send(1, s, r);
    check(r, s);
    bus(1'b1, IDX_MIRROR, 16'h0000);
    for (int m = 0; m < 4; m++) begin
      s = rnd();
      setsend(0, IDX_PLAY1_CTRL, 16'h0100 | 16'(m << 10), s, r);
      check(r, mixf(s, 2'(m)));
    end
    s = rnd();
    setsend(0, IDX_PLAY1_CTRL, 16'h0100, s, r);
    setsend(0, IDX_PLAY1_LGAIN, 16'h0000, s, r);
    check(r, s);
    setsend(0, IDX_PLAY1_RGAIN, 16'h01C8, s, r);
    check(48'({(r.left < 0 ? -r.left : r.left) < 64, r.right}), {24'h1, s.right});
    setsend(0, IDX_PLAY1_LGAIN, 16'h01C8, s, r);
    s.left = 24'h100000;
    s.right = 24'h100000;
    setsend(0, IDX_PLAY1_CTRL, 16'h0300, s, r);
    send(0, s, r);
    send(0, s, r);
    check(48'(r.left < s.left && r.left > 24'h080000), 48'h1);
    s = rnd();
    setsend(0, IDX_PLAY1_CTRL, 16'h0100, s, r);
    check(r, s);
    for (int k = 0; k < 2; k++) begin
      play1_ratio_i <= k == 0 ? RATIO_192FS : 3'h3;
      s.left = 24'h200000;
      s.right = 24'h200000;
      setsend(0, IDX_PLAY1_CTRL, 16'h0140, s, r);
      send(0, -s, r);
      send(0, s, r);
      check(48'(r === s), 48'(k == 0));
    end
    s.left = 24'h100000;
    s.right = 24'h100000;
    setsend(0, IDX_PLAY1_CTRL, 16'h0180, s, r);
    setsend(0, IDX_PLAY1_LGAIN, 16'h0164, s, r);
    check(r, s);
    s.left = 24'hF00000;
    s.right = 24'hF00000;
    send(0, s, r);
    send(0, s, r);
    check(r, {24'hF80000, s.right});
    bus(1'b1, IDX_PLAY1_CTRL, 16'h0100);
    for (int k = 0; k < 32; k++) begin
      s = rnd();
      setsend(2, IDX_REC_CTRL, 16'h1000 | 16'(k << 7), s, r);
      check(r, recf(s, 5'(k)));
    end
    s = rnd();
    setsend(2, IDX_REC_CTRL, 16'h1000, s, r);
    setsend(2, IDX_REC_LGAIN, 16'h0000, s, r);
    check(r, s);
    setsend(2, IDX_REC_RGAIN, 16'h01C3, s, r);
    check(r, {24'h0, s.right});
    s.left = 24'h100000;
    setsend(2, IDX_REC_CTRL, 16'h0000, s, r);
    send(2, s, r);
    send(2, s, r);
    check(48'(r.right !== s.right), 48'h1);
    final_report();
  end
endmodule
